// ==== hw/clk_switch_map.vh ====
// constants for the system clock switch control block: offsets, fields, resets, counts
// assumes an 8-bit register port and one-cycle source tick inputs sampled on ref_clk
`ifndef CLK_SWITCH_MAP_VH
`define CLK_SWITCH_MAP_VH

// register offsets
`define OSC_CTRL_ADDR       8'h00
`define TUNING_ADDR         8'h01
`define SEC_TIMER_CTRL_ADDR 8'h02
`define PRIMARY_CFG_ADDR    8'h03

// oscillator control fields
`define OSC_IDLE_BIT        7
`define OSC_FREQ_HI         6
`define OSC_FREQ_LO         4
`define OSC_PRIMARY_RDY_BIT 3
`define OSC_INT_STABLE_BIT  2
`define OSC_SRC_HI          1
`define OSC_SRC_LO          0

// tuning and secondary timer fields
`define TUNE_LOW_SRC_BIT    7
`define SEC_RUNNING_BIT     6
`define SEC_OSC_EN_BIT      3

// reset values
`define SRC_SEL_RESET       2'h0
`define FREQ_SEL_RESET      3'h4
`define SEC_TIMER_RESET     8'h00

// source codes
`define SRC_PRIMARY         2'h0
`define SRC_SECONDARY       2'h1
`define SRC_INTERNAL        2'h2

// frequency field codes
`define FREQ_LOW_RATE       3'h0
`define FREQ_FAST_FULL      3'h7

// timing counts in source cycles
`define OLD_PAUSE_TICKS     3'h2
`define NEW_PAUSE_TICKS     3'h3
`define STARTUP_TICKS       11'h400
`define LOW_RATE_DIVIDE     9'h100

`endif

// ==== hw/clock_switch_control.v ====
// system clock switch control: source select, internal block postscaler, status and sleep choice
// assumes oscillator ticks are one-cycle pulses synchronous to ref_clk, each one source rising edge
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "clk_switch_map.vh"

module clock_switch_control (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst_n,
    // register port
    input  wire [7:0] addr,
    input  wire [7:0] wr_data,
    input  wire       wr_stb,
    input  wire       rd_stb,
    output reg  [7:0] rd_data,
    // oscillator sources
    input  wire       primary_tick,
    input  wire       secondary_tick,
    input  wire       fast_osc_tick,
    input  wire       slow_rc_tick,
    input  wire       fast_osc_stable,
    input  wire [3:0] primary_osc_config,
    // power management
    input  wire       sleep_exec,
    input  wire       wake_event,
    // clock outputs
    output reg        device_clk_tick,
    output reg        monitor_clk_tick,
    // status outputs
    output reg        switch_busy,
    output reg        sleep_mode,
    output reg        idle_mode
);

    localparam ST_RUN   = 2'h0;
    localparam ST_DRAIN = 2'h1;
    localparam ST_FILL  = 2'h2;

    // software-visible control
    reg  [1:0]  clock_source_select_reg;
    reg  [2:0]  internal_freq_select_reg;
    reg         idle_on_sleep_reg;
    reg         low_rate_source_select_reg;
    reg  [7:0]  sec_timer_ctrl_reg;

    // switch sequencer
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [1:0]  active_src_reg;
    reg  [1:0]  target_src_reg;
    reg  [1:0]  target_src_next;
    reg  [2:0]  pause_cnt_reg;
    reg  [2:0]  pause_cnt_next;

    // primary startup timer
    reg  [10:0] startup_cnt_reg;
    wire        startup_done;

    // status flags
    reg         primary_clock_ready_reg;
    reg         internal_block_stable_reg;
    reg         secondary_clock_running_reg;

    wire        internal_tick;
    wire [1:0]  requested_src;
    wire [1:0]  wanted_src;
    wire        sec_osc_enable;
    wire        low_rate_rc;
    wire        osc_wr;
    reg         old_tick;
    reg         new_tick;
    reg         new_stable;
    reg         active_tick;
    reg         active_stable;

    // internal block output rate
    internal_postscaler u_postscaler (
        .ref_clk                (ref_clk),
        .rst_n                  (rst_n),
        .fast_tick              (fast_osc_tick),
        .slow_tick              (slow_rc_tick),
        .internal_freq_select   (internal_freq_select_reg),
        .low_rate_source_select (low_rate_source_select_reg),
        .internal_tick          (internal_tick)
    );

    // source decode: bit 1 alone marks the internal block
    assign requested_src = clock_source_select_reg[1] ? `SRC_INTERNAL :
                           (clock_source_select_reg[0] ? `SRC_SECONDARY : `SRC_PRIMARY);
    assign sec_osc_enable = sec_timer_ctrl_reg[`SEC_OSC_EN_BIT];
    // a secondary request with its oscillator off is ignored, the clock stays put
    assign wanted_src = (requested_src == `SRC_SECONDARY && !sec_osc_enable) ?
                        active_src_reg : requested_src;
    assign low_rate_rc = (internal_freq_select_reg == `FREQ_LOW_RATE) && !low_rate_source_select_reg;
    assign osc_wr = wr_stb && (addr == `OSC_CTRL_ADDR);
    assign startup_done = (startup_cnt_reg == `STARTUP_TICKS);

    // per-source tick and stability for the old and new side of a switch
    always @* begin
        case (active_src_reg)
            `SRC_PRIMARY: begin
                active_tick   = primary_tick;
                active_stable = startup_done;
            end
            `SRC_SECONDARY: begin
                active_tick   = secondary_tick;
                active_stable = 1'b1;
            end
            default: begin
                active_tick   = internal_tick;
                active_stable = fast_osc_stable || low_rate_rc;
            end
        endcase
        old_tick = active_tick;
        case (target_src_reg)
            `SRC_PRIMARY: begin
                new_tick   = primary_tick;
                new_stable = startup_done;
            end
            `SRC_SECONDARY: begin
                new_tick   = secondary_tick;
                new_stable = 1'b1;
            end
            default: begin
                new_tick   = internal_tick;
                new_stable = fast_osc_stable || low_rate_rc;
            end
        endcase
    end

    // control registers; all resets clear the source select and restore 1 MHz
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_source_select_reg    <= `SRC_SEL_RESET;
            internal_freq_select_reg   <= `FREQ_SEL_RESET;
            idle_on_sleep_reg          <= 1'b0;
            low_rate_source_select_reg <= 1'b0;
            sec_timer_ctrl_reg         <= `SEC_TIMER_RESET;
        end else if (wr_stb) begin
            case (addr)
                `OSC_CTRL_ADDR: begin
                    idle_on_sleep_reg        <= wr_data[`OSC_IDLE_BIT];
                    internal_freq_select_reg <= wr_data[`OSC_FREQ_HI:`OSC_FREQ_LO];
                    clock_source_select_reg  <= wr_data[`OSC_SRC_HI:`OSC_SRC_LO];
                end
                `TUNING_ADDR: begin
                    low_rate_source_select_reg <= wr_data[`TUNE_LOW_SRC_BIT];
                end
                `SEC_TIMER_CTRL_ADDR: begin
                    sec_timer_ctrl_reg <= wr_data;
                end
                default: begin
                    sec_timer_ctrl_reg <= sec_timer_ctrl_reg;
                end
            endcase
        end
    end

    // switch sequencer: drain old source, then wait for the new one to settle
    always @* begin
        state_next      = state_reg;
        target_src_next = target_src_reg;
        pause_cnt_next  = pause_cnt_reg;
        case (state_reg)
            ST_RUN: begin
                // a pending request is acted on in the same cycle it shows
                if (wanted_src != active_src_reg) begin
                    target_src_next = wanted_src;
                    pause_cnt_next  = 3'h0;
                    state_next      = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (old_tick) begin
                    if (pause_cnt_reg == `OLD_PAUSE_TICKS - 3'h1) begin
                        pause_cnt_next = 3'h0;
                        state_next     = ST_FILL;
                    end else begin
                        pause_cnt_next = pause_cnt_reg + 3'h1;
                    end
                end
            end
            ST_FILL: begin
                // only ticks of a stable new source count toward the pause
                if (new_tick && new_stable) begin
                    if (pause_cnt_reg == `NEW_PAUSE_TICKS - 3'h1) begin
                        pause_cnt_next = 3'h0;
                        state_next     = ST_RUN;
                    end else begin
                        pause_cnt_next = pause_cnt_reg + 3'h1;
                    end
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= ST_RUN;
            active_src_reg <= `SRC_PRIMARY;
            target_src_reg <= `SRC_PRIMARY;
            pause_cnt_reg  <= 3'h0;
        end else begin
            state_reg      <= state_next;
            target_src_reg <= target_src_next;
            pause_cnt_reg  <= pause_cnt_next;
            if (state_reg == ST_FILL && state_next == ST_RUN) begin
                active_src_reg <= target_src_reg;
            end
        end
    end

    // startup timer runs while the primary is wanted or in use, restarts otherwise
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            startup_cnt_reg <= 11'h000;
        end else if (wanted_src != `SRC_PRIMARY && active_src_reg != `SRC_PRIMARY) begin
            startup_cnt_reg <= 11'h000;
        end else if (primary_tick && !startup_done) begin
            startup_cnt_reg <= startup_cnt_reg + 11'h001;
        end
    end

    // source status flags; each needs its own source active, so one at most is set
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_clock_ready_reg     <= 1'b0;
            internal_block_stable_reg   <= 1'b0;
            secondary_clock_running_reg <= 1'b0;
        end else begin
            primary_clock_ready_reg     <= (state_next == ST_RUN) && (active_src_reg == `SRC_PRIMARY) &&
                                           startup_done;
            internal_block_stable_reg   <= (state_next == ST_RUN) && (active_src_reg == `SRC_INTERNAL) &&
                                           fast_osc_stable && !low_rate_rc;
            secondary_clock_running_reg <= (state_next == ST_RUN) &&
                                           (active_src_reg == `SRC_SECONDARY);
        end
    end

    // sleep instruction: idle keeps the device clock, sleep stops it until wake
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_mode <= 1'b0;
            idle_mode  <= 1'b0;
        end else if (wake_event) begin
            sleep_mode <= 1'b0;
            idle_mode  <= 1'b0;
        end else if (sleep_exec && !sleep_mode && !idle_mode) begin
            sleep_mode <= !idle_on_sleep_reg;
            idle_mode  <= idle_on_sleep_reg;
        end
    end

    // clock outputs; the device clock is held low for the whole switch pause
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            device_clk_tick  <= 1'b0;
            monitor_clk_tick <= 1'b0;
            switch_busy      <= 1'b0;
        end else begin
            // a request seen this edge already hides the tick, so busy and a device edge never overlap
            device_clk_tick  <= (state_reg == ST_RUN) && (state_next == ST_RUN) && active_stable &&
                                active_tick && !sleep_mode;
            monitor_clk_tick <= slow_rc_tick;
            switch_busy      <= (state_next != ST_RUN);
        end
    end

    // read port: data in the cycle after the strobe only, unmapped reads zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_stb) begin
            case (addr)
                `OSC_CTRL_ADDR: begin
                    rd_data <= {idle_on_sleep_reg, internal_freq_select_reg, primary_clock_ready_reg,
                                internal_block_stable_reg, clock_source_select_reg};
                end
                `TUNING_ADDR: begin
                    rd_data <= {low_rate_source_select_reg, 7'h00};
                end
                `SEC_TIMER_CTRL_ADDR: begin
                    rd_data <= {sec_timer_ctrl_reg[7], secondary_clock_running_reg,
                                sec_timer_ctrl_reg[5:0]};
                end
                `PRIMARY_CFG_ADDR: begin
                    rd_data <= {4'h0, primary_osc_config};
                end
                default: begin
                    rd_data <= 8'h00;
                end
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

endmodule // clock_switch_control

// ==== hw/internal_postscaler.v ====
// postscaler of the internal oscillator block: picks its output tick from the frequency field
// assumes fast_tick pulses at the fast oscillator rate and slow_tick at the slow rc rate
`timescale 1ns/1ps
`include "clk_switch_map.vh"

module internal_postscaler (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst_n,
    // source ticks
    input  wire       fast_tick,
    input  wire       slow_tick,
    // selection
    input  wire [2:0] internal_freq_select,
    input  wire       low_rate_source_select,
    // result
    output reg        internal_tick
);

    reg  [7:0] div_reg;
    wire [7:0] div_next;
    reg  [7:0] mask;

    // free-running divide chain of the fast oscillator
    assign div_next = div_reg + 8'h01;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 8'h00;
        end else if (fast_tick) begin
            div_reg <= div_next;
        end
    end

    // the mask is combinational so a field change acts on the very next tick
    always @* begin
        case (internal_freq_select)
            3'h1:    mask = 8'h3f;
            3'h2:    mask = 8'h1f;
            3'h3:    mask = 8'h0f;
            3'h4:    mask = 8'h07;
            3'h5:    mask = 8'h03;
            3'h6:    mask = 8'h01;
            3'h7:    mask = 8'h00;
            default: mask = 8'hff;
        endcase
        if (internal_freq_select == `FREQ_LOW_RATE && !low_rate_source_select) begin
            internal_tick = slow_tick;
        end else begin
            internal_tick = fast_tick && ((div_reg & mask) == mask);
        end
    end

endmodule // internal_postscaler

// ==== tb/clk_switch_monitor.sv ====
// checker for the clock switch control block: read port, status bits, pause and sleep relations
// assumes it is bound to clock_switch_control and sees only that module's ports
`timescale 1ns/1ps
`include "clk_switch_map.vh"

module clk_switch_monitor (
    // clock and reset
    input wire       ref_clk,
    input wire       rst_n,
    // register port
    input wire [7:0] addr,
    input wire       rd_stb,
    input wire [7:0] rd_data,
    // sources and power requests
    input wire [3:0] primary_osc_config,
    input wire       slow_rc_tick,
    input wire       sleep_exec,
    input wire       wake_event,
    // outputs under watch
    input wire       device_clk_tick,
    input wire       monitor_clk_tick,
    input wire       switch_busy,
    input wire       sleep_mode,
    input wire       idle_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // watchdog clock never leaves the slow rc, whatever the low-rate choice
    a_monitor_slow_rc: assert property (slow_rc_tick |=> monitor_clk_tick)
        else $error("monitor tick missing after slow rc tick");
    a_monitor_quiet: assert property (!slow_rc_tick |=> !monitor_clk_tick)
        else $error("monitor tick without slow rc tick");
    // a pause must hide every device edge, last a few cycles, and end in bounded time
    a_pause_no_tick: assert property (switch_busy |-> !device_clk_tick)
        else $error("device tick during switch pause");
    a_pause_min_len: assert property ($rose(switch_busy) |-> switch_busy[*3])
        else $error("switch pause too short");
    a_pause_bounded: assert property ($rose(switch_busy) |-> ##[1:1000] !switch_busy)
        else $error("switch pause never ends");
    // status bits of one register may never both be set
    a_status_single: assert property (rd_stb && addr == `OSC_CTRL_ADDR |=> !(rd_data[3] && rd_data[2]))
        else $error("two source status bits set");
    a_cfg_readback: assert property (rd_stb && addr == `PRIMARY_CFG_ADDR |=> rd_data == {4'h0, $past(primary_osc_config)})
        else $error("primary config read wrong");
    // sleep instruction gives exactly one of the two modes, wake clears both
    a_sleep_enter: assert property (sleep_exec && !wake_event |=> sleep_mode != idle_mode)
        else $error("sleep instruction gave no single mode");
    a_wake_clears: assert property (wake_event |=> !sleep_mode && !idle_mode)
        else $error("wake left a power mode set");
    a_sleep_stops: assert property (sleep_mode && $past(sleep_mode) |-> !device_clk_tick)
        else $error("device tick while sleeping");

    c_switch: cover property ($rose(switch_busy));
    c_sleep: cover property ($rose(sleep_mode));
    c_idle: cover property ($rose(idle_mode));
    c_cfg_read: cover property (rd_stb && addr == `PRIMARY_CFG_ADDR);
endmodule // clk_switch_monitor

bind clock_switch_control clk_switch_monitor mon_u (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
    .rd_stb(rd_stb), .rd_data(rd_data), .primary_osc_config(primary_osc_config), .slow_rc_tick(slow_rc_tick),
    .sleep_exec(sleep_exec), .wake_event(wake_event), .device_clk_tick(device_clk_tick),
    .monitor_clk_tick(monitor_clk_tick), .switch_busy(switch_busy), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode));

// ==== tb/clock_switch_control_tb.sv ====
// testbench for the clock switch control block: registers, switching, postscaler and sleep
// assumes a 50 MHz ref_clk; oscillator ticks are made here as one-cycle pulses
`timescale 1ns/1ps
`include "clk_switch_map.vh"

module clock_switch_control_tb;
    reg         ref_clk, rst_n, wr_stb, rd_stb, sleep_exec, wake_event;
    reg  [7:0]  addr, wr_data, v, got;
    reg         primary_tick, secondary_tick, fast_osc_tick, slow_rc_tick, fast_osc_stable;
    reg  [3:0]  primary_osc_config;
    reg  [31:0] rbit, r;
    wire [7:0]  rd_data;
    wire        device_clk_tick, monitor_clk_tick, switch_busy, sleep_mode, idle_mode;
    integer     seed, mismatches, n_checks, i, k, cnt, slow_cnt;

    clock_switch_control dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .primary_tick(primary_tick),
        .secondary_tick(secondary_tick), .fast_osc_tick(fast_osc_tick), .slow_rc_tick(slow_rc_tick),
        .fast_osc_stable(fast_osc_stable), .primary_osc_config(primary_osc_config),
        .sleep_exec(sleep_exec), .wake_event(wake_event), .device_clk_tick(device_clk_tick),
        .monitor_clk_tick(monitor_clk_tick), .switch_busy(switch_busy), .sleep_mode(sleep_mode),
        .idle_mode(idle_mode));

    always #10 ref_clk = ~ref_clk;

    // fast tick every other cycle keeps rates countable; others random so phases never line up
    always @(posedge ref_clk) begin
        rbit = $random(seed);
        fast_osc_tick  <= ~fast_osc_tick;
        primary_tick   <= rbit[0];
        secondary_tick <= rbit[5:4] == 2'h0;
        slow_rc_tick   <= rbit[3:1] == 3'h0;
    end

    task stop_test;
        begin
            if (mismatches == 0 && n_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task chk(input [15:0] seen, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // rates drift with tick phase, so counts are judged within a tolerance
    function near(input integer c, input integer e, input integer t);
        near = (c >= e - t) && (c <= e + t);
    endfunction

    task cyc;
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            addr    <= a;
            wr_data <= d;
            wr_stb  <= 1'b1;
            @(posedge ref_clk);
            wr_stb  <= 1'b0;
        end
    endtask

    task rd(input [7:0] a);
        begin
            @(posedge ref_clk);
            addr   <= a;
            rd_stb <= 1'b1;
            @(posedge ref_clk);
            rd_stb <= 1'b0;
            #1 got = rd_data;
        end
    endtask

    // pause length hangs on source phases, so wait for busy to come and go under a bound
    task wait_switch;
        begin
            for (i = 0; i < 20 && switch_busy !== 1'b1; i = i + 1)
                cyc;
            chk(switch_busy, 1'b1);
            for (i = 0; i < 2000 && switch_busy !== 1'b0; i = i + 1)
                cyc;
            if (switch_busy !== 1'b0) begin
                mismatches = mismatches + 1;
                stop_test;
            end
        end
    endtask

    task meas(input integer n);
        begin
            cnt = 0;
            slow_cnt = 0;
            repeat (n) begin
                cyc;
                cnt = cnt + (device_clk_tick === 1'b1);
                slow_cnt = slow_cnt + (slow_rc_tick === 1'b1);
            end
        end
    endtask

    initial begin
        #400000;
        mismatches = mismatches + 1;
        stop_test;
    end

    initial begin
        {ref_clk, rst_n, wr_stb, rd_stb, sleep_exec, wake_event} = 6'h00;
        {addr, wr_data, primary_osc_config} = 20'h00000;
        {primary_tick, secondary_tick, fast_osc_tick, slow_rc_tick, fast_osc_stable} = 5'h01;
        seed = 70548;
        mismatches = 0;
        n_checks = 0;
        repeat (12) @(posedge ref_clk);
        r = $random(seed);
        rst_n <= 1'b1;
        primary_osc_config <= r[3:0];
        rd(`OSC_CTRL_ADDR); chk(got, 8'h40);
        rd(`TUNING_ADDR); chk(got, 8'h00);
        rd(`SEC_TIMER_CTRL_ADDR); chk(got, `SEC_TIMER_RESET);
        rd(`PRIMARY_CFG_ADDR); chk(got, {4'h0, r[3:0]});
        rd(8'h04 | r[15:8]); chk(got, 8'h00);
        repeat (2600) @(posedge ref_clk);
        rd(`OSC_CTRL_ADDR); chk(got, 8'h48);
        // secondary select with its oscillator off must be ignored
        v = r[23:16] & 8'hb7;
        wr(`SEC_TIMER_CTRL_ADDR, v | 8'h40);
        rd(`SEC_TIMER_CTRL_ADDR); chk(got, v);
        wr(`OSC_CTRL_ADDR, 8'h41);
        repeat (10) begin
            cyc;
            chk(switch_busy, 1'b0);
        end
        rd(`OSC_CTRL_ADDR); chk(got & 8'h0c, 8'h08);
        wr(`SEC_TIMER_CTRL_ADDR, v | 8'h08);
        wr(`OSC_CTRL_ADDR, 8'h41);
        wait_switch;
        rd(`SEC_TIMER_CTRL_ADDR); chk(got, v | 8'h48);
        rd(`OSC_CTRL_ADDR); chk(got & 8'h0c, 8'h00);
        wr(`OSC_CTRL_ADDR, 8'h72);
        wait_switch;
        rd(`OSC_CTRL_ADDR); chk(got, 8'h76);
        rd(`SEC_TIMER_CTRL_ADDR); chk(got, v | 8'h08);
        meas(512); chk(near(cnt, 256, 2), 1'b1);
        wr(`OSC_CTRL_ADDR, 8'h42);
        meas(512); chk(near(cnt, 32, 2), 1'b1);
        wr(`TUNING_ADDR, 8'h80);
        wr(`OSC_CTRL_ADDR, 8'h02);
        meas(1024); chk(near(cnt, 2, 1), 1'b1);
        wr(`TUNING_ADDR, 8'h00);
        meas(512); chk(near(cnt, slow_cnt, 2), 1'b1);
        rd(`OSC_CTRL_ADDR); chk(got, 8'h02);
        // sleep stops the device clock, idle keeps it running
        for (k = 0; k < 2; k = k + 1) begin
            wr(`OSC_CTRL_ADDR, {k[0], 7'h72});
            @(posedge ref_clk);
            sleep_exec <= 1'b1;
            @(posedge ref_clk);
            sleep_exec <= 1'b0;
            #1 chk({sleep_mode, idle_mode}, {~k[0], k[0]});
            repeat (2) @(posedge ref_clk);
            meas(40); chk(cnt > 0, k[0]);
            @(posedge ref_clk);
            wake_event <= 1'b1;
            @(posedge ref_clk);
            wake_event <= 1'b0;
            #1 chk({sleep_mode, idle_mode}, 2'h0);
        end
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`OSC_CTRL_ADDR); chk(got, 8'h40);
        stop_test;
    end
endmodule // clock_switch_control_tb
